// *** hdl/erase_pkg.sv ***
/*
 erase_pkg: opcodes, geometry and timing constants for the erase and
 write-enable command block.
 Assumes a 40 MHz core clock and an SPI link clock from the host.
*/
package erase_pkg;
    localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
    localparam logic [7:0] OP_BLOCK_4K = 8'h20;
    localparam logic [7:0] OP_BLOCK_32K_A = 8'h52;
    localparam logic [7:0] OP_BLOCK_32K_B = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h62;
    localparam logic [7:0] OP_CHIP_ERASE_C = 8'hC7;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam int ADDR_BYTES = 3;
    localparam int PAGE_IDX_W = 7;
    localparam int ADDR_W = 24;
    localparam int BLOCK_4K_LSB = 12;
    localparam int BLOCK_32K_LSB = 15;
    localparam int CLK_MHZ = 40;
    localparam int PAGE_ERASE_TIME_US = 20;
    localparam int BLOCK_ERASE_TIME_US = 50;
    localparam int FULL_ARRAY_ERASE_TIME_US = 400;
    localparam int PAGE_ERASE_CYCLES = PAGE_ERASE_TIME_US * CLK_MHZ;
    localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;
    localparam int FULL_ARRAY_ERASE_CYCLES = FULL_ARRAY_ERASE_TIME_US * CLK_MHZ;
    localparam int TIMER_W = 24;
    typedef enum logic [2:0]
    {
        ERASE_NONE = 3'h0,
        ERASE_PAGE = 3'h1,
        ERASE_BLK4 = 3'h2,
        ERASE_BLK32 = 3'h3,
        ERASE_CHIP = 3'h4,
        CMD_WREN = 3'h5,
        CMD_WRDI = 3'h6
    } cmd_kind_t;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_ERASE = 2'h1,
        ST_FINISH = 2'h2
    } erase_state_t;
endpackage

// *** hdl/frame_capture.sv ***
/*
 frame_capture: serial shift logic on the link clock. Collects opcode and
 address bytes MSB first while select is low.
 Assumes the link clock only runs during frames; frame-level results are
 read by the core clock domain after select rises.
*/
`timescale 1ns/1ps
module frame_capture
    import erase_pkg::*;
(
    input wire logic link_clk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic [7:0] opcode_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [2:0] byte_count_o,
    output logic [2:0] bit_count_o
);
    logic [7:0] shift;
    logic [2:0] bits;
    logic [2:0] bytes;
    logic [7:0] next_byte;

    assign next_byte = {shift[6:0], si_i};

    // bit counter is cleared whenever select is high,
    // done asynchronously by cs_n so no edge after the frame is needed
    always_ff @(posedge link_clk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            bits <= 3'h0;
        end
        else
        begin
            bits <= bits + 3'h1; // see RL21
        end
    end

    always_ff @(posedge link_clk_i)
    begin
        shift <= next_byte; // see RL21
    end

    // byte counter must survive cs rise so the core can judge the frame
    logic frame_open;
    always_ff @(posedge link_clk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            frame_open <= 1'b0;
        end
        else
        begin
            frame_open <= 1'b1;
        end
    end

    always_ff @(posedge link_clk_i)
    begin
        if (!frame_open)
        begin
            bit_count_o <= 3'h1;
            byte_count_o <= 3'h0;
            opcode_o <= 8'h00;
            addr_o <= '0;
        end
        else
        begin
            bit_count_o <= bits + 3'h1;
            if (bits == 3'h7)
            begin
                if (byte_count_o != 3'h7)
                begin
                    byte_count_o <= byte_count_o + 3'h1;
                end
                if (byte_count_o == 3'h0)
                begin
                    opcode_o <= next_byte;
                end
                else if (byte_count_o <= 3'(ADDR_BYTES))
                begin
                    addr_o <= {addr_o[ADDR_W-9:0], next_byte}; // see RL7
                end
            end
        end
    end
endmodule

// *** hdl/erase_sequencer.sv ***
/*
 erase_sequencer: decodes erase and write-enable commands, judges each clocked frame
 on select release, runs self-timed erases and keeps the status flags.
 Assumes a frame_capture instance on the link clock; the erase array
 itself sits outside and answers with a fail pulse.
*/
// What this block does
// RL1: page erase 81h, three address bytes, 7-bit page index in middle byte.
// RL2: on select rise after page erase, erase the selected page self-timed.
// RL3: report busy while a page erase runs.
// RL4: erase failure on any byte raises the erase/program error flag.
// RL5: 20h erases 4 KB block, 52h or D8h erase 32 KB block.
// RL6: erase commands run only when the write-enable latch is already set.
// RL7: block erase takes three address bytes, ignores more, starts on select rise.
// RL8: block erase ignores A11-A0 for 4 KB, A14-A0 for 32 KB.
// RL9: block erase aborts on short address or off-byte select release.
// RL10: protected memory blocks block erase; return to idle on release.
// RL11: block erase abort or protection clears the write-enable latch.
// RL12: busy stays visible during erase; latch cleared before erase ends.
// RL13: host should poll busy rather than wait the worst-case time.
// RL14: 60h, 62h, C7h erase the whole array on select rise, no address.
// RL15: chip erase needs full opcode and byte-aligned select release.
// RL16: protected chip erase refused; off-boundary or protected clears latch.
// RL17: 06h sets the write-enable latch on select rise.
// RL18: 04h clears the write-enable latch on select rise.
// RL19: partial or misaligned latch commands leave the latch unchanged.
// RL20: array protect bit set means whole array protected.
// RL21: bytes shift in MSB first on rising link clock while select low.
`timescale 1ns/1ps
module erase_sequencer
    import erase_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic array_protect_bit_i,
    input wire logic erase_fail_i,
    output logic ready_busy_o,
    output logic write_enable_latch_o,
    output logic erase_program_error_flag_o,
    output logic erase_start_o,
    output logic [2:0] erase_kind_o,
    output logic [ADDR_W-1:0] erase_addr_o,
    output logic [PAGE_IDX_W-1:0] page_index_o
);
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
    logic [2:0] byte_count;
    logic [2:0] bit_count;

    frame_capture capture
    (
        .link_clk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .si_i(si_i),
        .opcode_o(opcode),
        .addr_o(addr),
        .byte_count_o(byte_count),
        .bit_count_o(bit_count)
    );

    // link-side frame toggle: flips on the first link clock edge of a frame,
    // so the core can drop a frame that carried no clock at all; the capture
    // words would otherwise still hold the previous frame's command
    logic link_active;
    logic frame_seq;

    always_ff @(posedge sclk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
        begin
            link_active <= 1'b0;
        end
        else
        begin
            link_active <= 1'b1;
        end
    end

    // core reset taken asynchronously here: the link clock is idle during reset
    always_ff @(posedge sclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            frame_seq <= 1'b0;
        end
        else if (!link_active)
        begin
            frame_seq <= ~frame_seq;
        end
    end

    // select synchroniser; frame words are stable once select is high
    logic cs_meta;
    logic cs_sync;
    logic cs_sync_d;
    logic frame_end;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_sync_d <= 1'b1;
        end
        else
        begin
            cs_meta <= cs_n_i;
            cs_sync <= cs_meta;
            cs_sync_d <= cs_sync;
        end
    end

    assign frame_end = cs_sync && !cs_sync_d;

    // the link clock stops at frame end, so these words hold still here;
    // two flip-flops on every word, like any other crossing, before decode
    logic [7:0] opcode_s;
    logic [ADDR_W-1:0] addr_s;
    logic [2:0] byte_count_s;
    logic [2:0] bit_count_s;
    logic seq_s;
    logic [7:0] opcode_q;
    logic [ADDR_W-1:0] addr_q;
    logic [2:0] byte_count_q;
    logic aligned_q;
    logic seq_q;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            opcode_s <= 8'h00;
            addr_s <= '0;
            byte_count_s <= 3'h0;
            bit_count_s <= 3'h0;
            seq_s <= 1'b0;
            opcode_q <= 8'h00;
            addr_q <= '0;
            byte_count_q <= 3'h0;
            aligned_q <= 1'b0;
            seq_q <= 1'b0;
        end
        else
        begin
            opcode_s <= opcode;
            addr_s <= addr;
            byte_count_s <= byte_count;
            bit_count_s <= bit_count;
            seq_s <= frame_seq;
            opcode_q <= opcode_s;
            addr_q <= addr_s;
            byte_count_q <= byte_count_s;
            // bit counter wraps to zero on every eighth bit
            aligned_q <= (bit_count_s == 3'h0);
            seq_q <= seq_s;
        end
    end

    cmd_kind_t kind;
    always_comb
    begin
        case (opcode_q)
            OP_PAGE_ERASE: kind = ERASE_PAGE; // see RL1
            OP_BLOCK_4K: kind = ERASE_BLK4; // see RL5
            OP_BLOCK_32K_A, OP_BLOCK_32K_B: kind = ERASE_BLK32; // see RL5
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_CHIP_ERASE_C: kind = ERASE_CHIP; // see RL14
            OP_WRITE_ENABLE: kind = CMD_WREN;
            OP_WRITE_DISABLE: kind = CMD_WRDI;
            default: kind = ERASE_NONE;
        endcase
    end

    logic needs_addr;
    logic is_erase;
    logic complete;
    logic frame_ok;
    assign is_erase = (kind == ERASE_PAGE) || (kind == ERASE_BLK4) ||
                      (kind == ERASE_BLK32) || (kind == ERASE_CHIP);
    assign needs_addr = (kind == ERASE_PAGE) || (kind == ERASE_BLK4) || (kind == ERASE_BLK32);
    // byte counter saturates so any extra bytes are simply ignored
    assign complete = needs_addr ? (byte_count_q >= 3'(ADDR_BYTES + 1)) : (byte_count_q >= 3'h1);
    assign frame_ok = complete && aligned_q; // see RL9 RL15

    erase_state_t state;
    erase_state_t next_state;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] erase_len;
    logic start_ok;
    logic start_bad;

    // busy device ignores new commands; judged one cycle after capture;
    // a frame without link clocks leaves the toggle alone and is dropped,
    // otherwise the last clocked command would be applied a second time
    logic judge;
    logic judged_seq;
    logic judge_ok;
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            judge <= 1'b0;
            judged_seq <= 1'b0;
        end
        else
        begin
            judge <= frame_end;
            if (judge)
            begin
                judged_seq <= seq_q;
            end
        end
    end

    assign judge_ok = judge && (seq_q != judged_seq);

    assign start_ok = judge_ok && (state == ST_IDLE) && is_erase && frame_ok &&
                      write_enable_latch_o && !array_protect_bit_i; // see RL6 RL20
    assign start_bad = judge_ok && (state == ST_IDLE) && is_erase && write_enable_latch_o &&
                       (!frame_ok || array_protect_bit_i); // see RL10 RL16

    always_comb
    begin
        case (kind)
            ERASE_PAGE: erase_len = TIMER_W'(PAGE_ERASE_CYCLES);
            ERASE_CHIP: erase_len = TIMER_W'(FULL_ARRAY_ERASE_CYCLES);
            default: erase_len = TIMER_W'(BLOCK_ERASE_CYCLES);
        endcase
    end

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (start_ok)
                begin
                    next_state = ST_ERASE; // see RL2
                end
            end
            ST_ERASE:
            begin
                if (timer == '0)
                begin
                    next_state = ST_FINISH;
                end
            end
            ST_FINISH: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            timer <= '0;
        end
        else if (start_ok)
        begin
            timer <= erase_len - TIMER_W'(1);
        end
        else if (state == ST_ERASE && timer != '0)
        begin
            timer <= timer - TIMER_W'(1);
        end
    end

    assign ready_busy_o = (state != ST_IDLE); // see RL3 RL12

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            write_enable_latch_o <= 1'b0;
        end
        else if (start_bad)
        begin
            write_enable_latch_o <= 1'b0; // see RL11
        end
        else if (state == ST_ERASE)
        begin
            write_enable_latch_o <= 1'b0; // see RL12
        end
        else if (judge_ok && state == ST_IDLE && frame_ok && kind == CMD_WREN)
        begin
            write_enable_latch_o <= 1'b1; // see RL17
        end
        else if (judge_ok && state == ST_IDLE && frame_ok && kind == CMD_WRDI)
        begin
            write_enable_latch_o <= 1'b0; // see RL18
        end
        // misaligned or partial latch commands fall through unchanged, see RL19
    end

    // error flag is sticky until a new erase starts; a fail pulse counts only
    // in ST_ERASE, so one in the start cycle is ignored
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            erase_program_error_flag_o <= 1'b0;
        end
        else if (state == ST_ERASE && erase_fail_i)
        begin
            erase_program_error_flag_o <= 1'b1; // see RL4
        end
        else if (start_ok)
        begin
            erase_program_error_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            erase_start_o <= 1'b0;
            erase_kind_o <= 3'h0;
            erase_addr_o <= '0;
            page_index_o <= '0;
        end
        else
        begin
            erase_start_o <= start_ok;
            if (start_ok)
            begin
                erase_kind_o <= kind;
                page_index_o <= addr_q[8 +: PAGE_IDX_W]; // see RL1
                case (kind)
                    ERASE_BLK4: erase_addr_o <= {addr_q[ADDR_W-1:BLOCK_4K_LSB], 12'h000}; // see RL8
                    ERASE_BLK32: erase_addr_o <= {addr_q[ADDR_W-1:BLOCK_32K_LSB], 15'h0000}; // see RL8
                    ERASE_PAGE: erase_addr_o <= {8'h00, 1'b0, addr_q[8 +: PAGE_IDX_W], 8'h00};
                    default: erase_addr_o <= '0;
                endcase
            end
        end
    end
endmodule

// *** sim/erase_sequencer_asserts.sv ***
/*
 erase_sequencer_asserts: port checker for erase_sequencer.
 Assumes it is bound to the sequencer from the bench top.
*/
`timescale 1ns/1ps
module erase_sequencer_asserts
    import erase_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic array_protect_bit_i,
    input wire logic erase_fail_i,
    input wire logic ready_busy_o,
    input wire logic write_enable_latch_o,
    input wire logic erase_program_error_flag_o,
    input wire logic erase_start_o,
    input wire logic [2:0] erase_kind_o,
    input wire logic [ADDR_W-1:0] erase_addr_o,
    input wire logic [PAGE_IDX_W-1:0] page_index_o
);
    int busy_len;
    // counter stands in for a repetition far too long to unroll
    always_ff @(posedge clock_i)
        if (!rst_n_i || !ready_busy_o)
            busy_len <= 0;
        else
            busy_len <= busy_len + 1;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_start_needs_latch: assert property (erase_start_o |-> write_enable_latch_o)
        else $error("erase started with latch low");
    a_start_unprotected: assert property (erase_start_o |-> !$past(array_protect_bit_i))
        else $error("erase started while protected");
    a_latch_clears: assert property (erase_start_o |=> !write_enable_latch_o && ready_busy_o)
        else $error("latch not cleared or busy low after start");
    a_kind_legal: assert property (erase_start_o |-> erase_kind_o inside {3'h1, 3'h2, 3'h3, 3'h4})
        else $error("erase kind out of range");
    a_blk4_align: assert property (erase_start_o && erase_kind_o == 3'h2 |-> erase_addr_o[11:0] == 12'h000)
        else $error("4K base not aligned");
    a_blk32_align: assert property (erase_start_o && erase_kind_o == 3'h3 |-> erase_addr_o[14:0] == 15'h0000)
        else $error("32K base not aligned");
    a_start_after_release: assert property (erase_start_o |-> cs_n_i && $past(cs_n_i, 2))
        else $error("erase started with select low");
    a_busy_bound: assert property (busy_len <= FULL_ARRAY_ERASE_CYCLES + 1)
        else $error("busy held too long");
    a_error_sticky: assert property ($fell(erase_program_error_flag_o) |-> erase_start_o || $past(erase_start_o))
        else $error("error flag dropped outside erase start");
    a_latch_on_release: assert property ($changed(write_enable_latch_o) |-> cs_n_i)
        else $error("latch moved with select low");
    cover property (erase_start_o && erase_kind_o == 3'h4);
    cover property ($rose(erase_program_error_flag_o));
    cover property ($fell(write_enable_latch_o) && !ready_busy_o);
endmodule

// *** sim/spi_host_model.sv ***
/*
 spi_host_model: host side of the serial link, mode 0.
 Assumes the bench calls frame(); link clock idles low between frames.
*/
`timescale 1ns/1ps
module spi_host_model
(
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b1;
    end
    // n bits from bit 39 down; n not a multiple of 8 ends off a byte boundary on purpose
    task automatic frame(input logic [39:0] bits, input int n);
        #13 cs_n_o = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            si_o = bits[39 - i];
            #62.5 sclk_o = 1'b1;
            #62.5 sclk_o = 1'b0;
        end
        #40 cs_n_o = 1'b1;
        si_o = ~si_o;
    endtask
endmodule

// *** sim/erase_sequencer_tb.sv ***
/*
 erase_sequencer_tb: self-checking bench for erase_sequencer.
 Assumes spi_host_model drives the link; erase_fail_i fakes the array.
*/
`timescale 1ns/1ps
module erase_sequencer_tb;
    import erase_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic array_protect_bit_i = 1'b0;
    logic erase_fail_i = 1'b0;
    logic sclk_i, cs_n_i, si_i, ready_busy_o, write_enable_latch_o, erase_program_error_flag_o, erase_start_o;
    logic [2:0] erase_kind_o, kind_seen;
    logic [ADDR_W-1:0] erase_addr_o, addr_seen;
    logic [PAGE_IDX_W-1:0] page_index_o, idx_seen;
    int fail_count = 0;
    int checks = 0;
    int starts = 0;
    always #12.5 clock_i = ~clock_i;
    spi_host_model u_spi_host_model (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .si_o(si_i));
    erase_sequencer u_erase_sequencer (.clock_i, .rst_n_i, .sclk_i, .cs_n_i, .si_i, .array_protect_bit_i,
        .erase_fail_i, .ready_busy_o, .write_enable_latch_o, .erase_program_error_flag_o, .erase_start_o,
        .erase_kind_o, .erase_addr_o, .page_index_o);
    always @(posedge clock_i)
        if (erase_start_o === 1'b1)
        begin
            starts <= starts + 1;
            kind_seen <= erase_kind_o;
            addr_seen <= erase_addr_o;
            idx_seen <= page_index_o;
        end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // gap of 10 clocks covers the select synchroniser and judge
    task automatic send(input logic [39:0] b, input int n);
        u_spi_host_model.frame(b, n);
        repeat (10) @(posedge clock_i);
    endtask
    task automatic latch_cmds;
        send({OP_WRITE_ENABLE, 32'h0}, 8);
        check("latch set", write_enable_latch_o, 1);
        send({OP_WRITE_DISABLE, 32'h0}, 7);
        check("latch short", write_enable_latch_o, 1);
        send({OP_WRITE_DISABLE, 32'h0}, 12);
        check("latch misaligned", write_enable_latch_o, 1);
        send({OP_WRITE_DISABLE, 32'hFF00_0000}, 16);
        check("latch clear", write_enable_latch_o, 0);
        send({OP_WRITE_ENABLE, 32'h0}, 5);
        check("latch kept low", write_enable_latch_o, 0);
    endtask
    task automatic erase_kinds;
        logic [7:0] ops [7] = '{OP_PAGE_ERASE, OP_BLOCK_4K, OP_BLOCK_32K_A, OP_BLOCK_32K_B,
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_CHIP_ERASE_C};
        logic [2:0] kinds [7] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h4};
        int n;
        for (int i = 0; i < 7; i++)
        begin
            n = starts;
            send({OP_WRITE_ENABLE, 32'h0}, 8);
            erase_fail_i <= (i == 0);
            send({ops[i], 24'h5AA5FF, 8'h77}, kinds[i] == 3'h1 ? 32 : kinds[i] == 3'h4 ? 16 : 40);
            check("starts", starts, n + 1);
            check("kind", kind_seen, kinds[i]);
            check("busy", ready_busy_o, 1);
            check("latch in erase", write_enable_latch_o, 0);
            if (kinds[i] == 3'h1)
                check("page index", idx_seen, 7'h25);
            if (kinds[i] == 3'h2)
                check("4K base", addr_seen, 24'h5AA000);
            if (kinds[i] == 3'h3)
                check("32K base", addr_seen, 24'h5A8000);
            if (i == 6)
            begin
                send({OP_WRITE_ENABLE, 32'h0}, 8);
                check("latch while busy", write_enable_latch_o, 0);
            end
            for (int k = 0; k < 20000 && ready_busy_o !== 1'b0; k++)
                @(posedge clock_i);
            erase_fail_i <= 1'b0;
            check("busy end", ready_busy_o, 0);
            check("error flag", erase_program_error_flag_o, i == 0);
            if (i == 6)
            begin
                send({OP_WRITE_ENABLE, 32'h0}, 0);
                check("empty frame", write_enable_latch_o, 0);
            end
        end
    endtask
    // each entry ends short, off a byte, or hits protection
    task automatic aborts;
        logic [39:0] fr [6] = '{{OP_BLOCK_4K, 32'h0}, {OP_BLOCK_4K, 24'h001000, 8'hA0},
            {OP_CHIP_ERASE_A, 32'h0}, {OP_BLOCK_4K, 32'h0}, {OP_CHIP_ERASE_C, 32'h0}, {OP_PAGE_ERASE, 32'h0}};
        int len [6] = '{24, 35, 12, 32, 8, 32};
        int n;
        n = starts;
        send({OP_BLOCK_4K, 24'h001000, 8'h0}, 32);
        check("no latch", starts, n);
        for (int i = 0; i < 6; i++)
        begin
            array_protect_bit_i <= (i >= 3);
            send({OP_WRITE_ENABLE, 32'h0}, 8);
            send(fr[i], len[i]);
            check("abort starts", starts, n);
            check("abort latch", write_enable_latch_o, 0);
        end
        array_protect_bit_i <= 1'b0;
    endtask
    initial
    begin
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        latch_cmds;
        erase_kinds;
        aborts;
        results;
    end
    initial
    begin
        repeat (90000) @(posedge clock_i);
        fail_count++;
        results;
    end
endmodule
bind erase_sequencer erase_sequencer_asserts u_erase_sequencer_asserts (.clock_i, .rst_n_i, .sclk_i, .cs_n_i, .si_i,
    .array_protect_bit_i, .erase_fail_i, .ready_busy_o, .write_enable_latch_o, .erase_program_error_flag_o,
    .erase_start_o, .erase_kind_o, .erase_addr_o, .page_index_o);
